// File: hdl/completion_queue_cfg.svh
// What this block does
// R01: software places the second receive queue's 256-byte aligned host start address in bits 31:8.
// R02: the second receive queue spans 4 KB or 8 KB of host memory as the size bit 5 selects.
// R03: with bit 7 set the second receive queue is reached with 64-bit addressing cycles.
// R04: software writes to the second receive producer index take effect only while bit 6 is set.
// R05: the two-bit format field picks one, two, two or four word entries for codes 00 to 11.
// R06: the fill threshold is four times the 4-bit threshold field.
// R07: transmit sense bit 31 picks empty-at-or-below or valid-at-or-above for its status.
// R08: first receive sense bit 15 picks empty-at-or-below or valid-at-or-above for its status.
// R09: a queue is empty when its producer and consumer indices match.
// R10: a queue is full when producer plus one equals consumer; a full second receive queue then gets no more entries.
// R11: an index counts 4-byte units with the size bit clear and 8-byte units with it set.
// R12: the transmit consumer index in bits 25:16 is written by software and read by the block.
// R13: the first receive consumer index in bits 9:0 is written by software and read by the block.
// R14: consumer register bits 30:26 and 14:10 read as zero and are written as zero.
// R15: software loads the base address before enabling the queue; the block only reads it.
// R16: each entry delivered to host memory advances the producer index by one, unless a software producer load lands in the same cycle; the load wins.
// R17: the entry address is base plus the scaled producer index, the index wrapping at queue size.
`ifndef COMPLETION_QUEUE_CFG_SVH
`define COMPLETION_QUEUE_CFG_SVH

// ==========================================================
// register offsets
`define OFS_RXQ2_CONTROL   12'h0_0C0
`define OFS_CONSUMER_IDX   12'h0_0C4
`define OFS_RXQ2_POINTERS  12'h0_0E0
`define OFS_QUEUE_CONFIG   12'h0_0E4
`define OFS_QUEUE_STATUS   12'h0_0E8

// ==========================================================
// field positions
`define RXQ2_BASE_MSB      31
`define RXQ2_BASE_LSB      8
`define RXQ2_WIDE_BIT      7
`define RXQ2_PWE_BIT       6
`define RXQ2_SIZE_BIT      5
`define FMT_MSB            5
`define FMT_LSB            4
`define THR_MSB            3
`define THR_LSB            0
`define TXQ_SENSE_BIT      31
`define HI_IDX_MSB         25
`define HI_IDX_LSB         16
`define RXQ1_SENSE_BIT     15
`define LO_IDX_MSB         9
`define LO_IDX_LSB         0
`define CFG_TXQ_SIZE_BIT   4
`define CFG_RXQ1_THR_LSB   8
`define CFG_RXQ1_SIZE_BIT  12

// ==========================================================
// reset values and sizes
`define RST_RXQ2_CONTROL   32'h0000_0000
`define RST_CONSUMER_IDX   32'h0000_0000
`define RST_WORD           32'h0000_0000
`define CONSUMER_MASK      32'h83FF_83FF
`define POINTERS_MASK      32'h03FF_83FF
`define CONFIG_MASK        32'h0000_1F1F
`define QUEUE_LAST_ENTRY   10'h3_FF

`endif

// File: hdl/completion_queue_control.sv
`timescale 1ns/1ps
`include "completion_queue_cfg.svh"

module completion_queue_control (
   input  wire logic        clock,             // core clock, 200 MHz
   input  wire logic        reset_n,           // asynchronous reset, active low
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb enable
   input  wire logic        pwrite,            // apb direction
   input  wire logic [11:0] paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic             pready,            // apb ready
   output logic [31:0]      prdata,            // apb read data
   output logic             pslverr,           // apb error, unmapped address
   input  wire logic [9:0]  txqProducer,       // transmit producer index
   input  wire logic [9:0]  rxq1Producer,      // first receive producer index
   input  wire logic        entryReq,          // entry waiting for second receive queue
   input  wire logic        dmaDone,           // bus master finished the entry
   output logic             dmaReq,            // entry write request
   output logic [31:0]      dmaAddr,           // host address of the entry
   output logic             dmaWide,           // use 64-bit addressing cycles
   output logic [2:0]       dmaWords,          // words in the entry
   output logic             entryWritten,      // pulse per delivered entry
   output logic             txqCompletionIrq,  // transmit threshold status
   output logic             rxq1CompletionIrq, // first receive threshold status
   output logic             rxq2CompletionIrq  // second receive threshold status
);

   // ==========================================================
   // register state
   logic [31:0] rxq2Control_r;
   logic [31:0] consumerIdx_r;
   logic [31:0] consumerIdx_nxt;
   logic [9:0]  rxq2Producer_r;
   logic [9:0]  rxq2Producer_nxt;
   logic [9:0]  rxq2Consumer_r;
   logic        rxq2Sense_r;
   logic [31:0] queueConfig_r;
   completion_queue_pkg::engine_state_t state_r;
   completion_queue_pkg::engine_state_t state_nxt;

   logic        pready_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic        dmaReq_r;
   logic [31:0] dmaAddr_r;
   logic        dmaWide_r;
   logic [2:0]  dmaWords_r;
   logic        entryWritten_r;
   logic        txqIrq_r;
   logic        rxq1Irq_r;
   logic        rxq2Irq_r;

   // ==========================================================
   // apb decode
   logic        setupPhase;
   logic        writeTaken;
   logic        selControl;
   logic        selConsumer;
   logic        selPointers;
   logic        selConfig;
   logic        selStatus;
   logic        addrHit;
   logic [31:0] readMux;
   logic [31:0] statusWord;
   logic [31:0] pointersWord;

   assign setupPhase  = psel & ~penable;
   // a write lands only at the edge where the master sees ready
   assign writeTaken  = psel & penable & pready_r & pwrite & ~pslverr_r;
   assign selControl  = (paddr == `OFS_RXQ2_CONTROL);
   assign selConsumer = (paddr == `OFS_CONSUMER_IDX);
   assign selPointers = (paddr == `OFS_RXQ2_POINTERS);
   assign selConfig   = (paddr == `OFS_QUEUE_CONFIG);
   assign selStatus   = (paddr == `OFS_QUEUE_STATUS);
   assign addrHit     = selControl | selConsumer | selPointers | selConfig | selStatus;

   // ==========================================================
   // field views
   logic [31:0] rxq2Base;
   logic        rxq2Wide;
   logic        rxq2ProducerWe;
   logic        rxq2Size;
   logic [1:0]  rxq2Format;
   logic [3:0]  rxq2Threshold;
   logic [9:0]  txqConsumer;
   logic [9:0]  rxq1Consumer;
   logic        txqSense;
   logic        rxq1Sense;
   logic [3:0]  txqThreshold;
   logic [3:0]  rxq1Threshold;

   // base is 256-byte aligned by construction: its low byte is tied to zero
   assign rxq2Base       = {rxq2Control_r[`RXQ2_BASE_MSB:`RXQ2_BASE_LSB], 8'h00}; // R01 R15
   assign rxq2Wide       = rxq2Control_r[`RXQ2_WIDE_BIT];
   assign rxq2ProducerWe = rxq2Control_r[`RXQ2_PWE_BIT];
   assign rxq2Size       = rxq2Control_r[`RXQ2_SIZE_BIT];
   assign rxq2Format     = rxq2Control_r[`FMT_MSB:`FMT_LSB];
   assign rxq2Threshold  = rxq2Control_r[`THR_MSB:`THR_LSB];
   assign txqConsumer    = consumerIdx_r[`HI_IDX_MSB:`HI_IDX_LSB];                // R12
   assign rxq1Consumer   = consumerIdx_r[`LO_IDX_MSB:`LO_IDX_LSB];                // R13
   assign txqSense       = consumerIdx_r[`TXQ_SENSE_BIT];
   assign rxq1Sense      = consumerIdx_r[`RXQ1_SENSE_BIT];
   assign txqThreshold   = queueConfig_r[`THR_MSB:`THR_LSB];
   assign rxq1Threshold  = queueConfig_r[`CFG_RXQ1_THR_LSB+3:`CFG_RXQ1_THR_LSB];

   // ==========================================================
   // queue trackers, one per completion queue
   logic txqEmpty, txqFull, txqHit;
   logic rxq1Empty, rxq1Full, rxq1Hit;
   logic rxq2Empty, rxq2Full, rxq2Hit;

   queue_tracker txqTrack (
      .producer     (txqProducer),
      .consumer     (txqConsumer),
      .thresholdFld (txqThreshold),
      .sense        (txqSense),
      .empty        (txqEmpty),
      .full         (txqFull),
      .thresholdHit (txqHit)
   );

   queue_tracker rxq1Track (
      .producer     (rxq1Producer),
      .consumer     (rxq1Consumer),
      .thresholdFld (rxq1Threshold),
      .sense        (rxq1Sense),
      .empty        (rxq1Empty),
      .full         (rxq1Full),
      .thresholdHit (rxq1Hit)
   );

   queue_tracker rxq2Track (
      .producer     (rxq2Producer_r),
      .consumer     (rxq2Consumer_r),
      .thresholdFld (rxq2Threshold),
      .sense        (rxq2Sense_r),
      .empty        (rxq2Empty),
      .full         (rxq2Full),
      .thresholdHit (rxq2Hit)
   );

   // ==========================================================
   // read data
   assign pointersWord = {6'h00, rxq2Producer_r, rxq2Sense_r, 5'h00, rxq2Consumer_r};
   assign statusWord   = {23'h00_0000, rxq2Hit, rxq2Full, rxq2Empty,
                          rxq1Hit, rxq1Full, rxq1Empty, txqHit, txqFull, txqEmpty};
   // reserved consumer bits are never stored, so they read as zero
   assign readMux = selControl  ? rxq2Control_r :
                    selConsumer ? consumerIdx_r :                              // R14
                    selPointers ? pointersWord  :
                    selConfig   ? queueConfig_r :
                    selStatus   ? statusWord    : 32'h0000_0000;

   // ==========================================================
   // descriptor address and size
   logic [12:0] indexOffset;
   logic [31:0] entryAddr;
   logic [2:0]  entryWords;
   logic        engineStart;

   // 10-bit index spans 1024 entries: 4 KB of 4-byte or 8 KB of 8-byte units
   assign indexOffset = rxq2Size ? {rxq2Producer_r, 3'h0}                     // R11 R02
                                 : {1'b0, rxq2Producer_r, 2'h0};
   assign entryAddr   = rxq2Base + {19'h0_0000, indexOffset};                 // R17
   assign entryWords  = (rxq2Format == completion_queue_pkg::FMT_ONE_WORD)  ? 3'h1 : // R05
                        (rxq2Format == completion_queue_pkg::FMT_FOUR_WORD) ? 3'h4 : 3'h2;
   // a queue whose producer is open to software takes no entries
   assign engineStart = entryReq & ~rxq2Full & ~rxq2ProducerWe;               // R10

   // ==========================================================
   // engine sequencing
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         completion_queue_pkg::ENG_IDLE: begin
            if (engineStart) begin
               state_nxt = completion_queue_pkg::ENG_WRITE;
            end
         end
         completion_queue_pkg::ENG_WRITE: begin
            if (dmaDone) begin
               state_nxt = completion_queue_pkg::ENG_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // producer and consumer index next values
   logic        entryDone;
   logic        swProducerWrite;

   assign entryDone       = (state_r == completion_queue_pkg::ENG_WRITE) & dmaDone;
   assign swProducerWrite = writeTaken & selPointers & rxq2ProducerWe;         // R04
   // software load needs the engine held off, but an entry already in flight can finish in the same cycle; the load wins
   assign rxq2Producer_nxt = swProducerWrite ? pwdata[`HI_IDX_MSB:`HI_IDX_LSB] :
                             entryDone       ? 10'(rxq2Producer_r + 10'h001) : // R16
                                               rxq2Producer_r;
   assign consumerIdx_nxt = pwdata & `CONSUMER_MASK;                          // R14

   // ==========================================================
   // apb answer: ready in the first access cycle, zero wait
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r  <= setupPhase;
         prdata_r  <= setupPhase ? readMux : 32'h0000_0000;
         pslverr_r <= setupPhase & ~addrHit;
      end
   end

   // ==========================================================
   // software registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxq2Control_r <= `RST_RXQ2_CONTROL;
         consumerIdx_r <= `RST_CONSUMER_IDX;
         queueConfig_r <= `RST_WORD;
         rxq2Consumer_r <= 10'h000;
         rxq2Sense_r   <= 1'b0;
      end else if (writeTaken) begin
         if (selControl) begin
            rxq2Control_r <= pwdata;
         end
         if (selConsumer) begin
            consumerIdx_r <= consumerIdx_nxt;                                  // R12 R13
         end
         if (selConfig) begin
            queueConfig_r <= pwdata & `CONFIG_MASK;
         end
         if (selPointers) begin
            rxq2Consumer_r <= pwdata[`LO_IDX_MSB:`LO_IDX_LSB];
            rxq2Sense_r   <= pwdata[`RXQ1_SENSE_BIT];
         end
      end
   end

   // ==========================================================
   // engine and producer state
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r        <= completion_queue_pkg::ENG_IDLE;
         rxq2Producer_r <= 10'h000;
      end else begin
         state_r        <= state_nxt;
         rxq2Producer_r <= rxq2Producer_nxt;
      end
   end

   // ==========================================================
   // bus master request, held steady until the master finishes
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dmaReq_r       <= 1'b0;
         dmaAddr_r      <= 32'h0000_0000;
         dmaWide_r      <= 1'b0;
         dmaWords_r     <= 3'h0;
         entryWritten_r <= 1'b0;
      end else begin
         entryWritten_r <= entryDone;
         if ((state_r == completion_queue_pkg::ENG_IDLE) && engineStart) begin
            dmaReq_r   <= 1'b1;
            dmaAddr_r  <= entryAddr;                                           // R17
            dmaWide_r  <= rxq2Wide;                                            // R03
            dmaWords_r <= entryWords;                                          // R05
         end else if (entryDone) begin
            dmaReq_r   <= 1'b0;
         end
      end
   end

   // ==========================================================
   // threshold status, registered so outputs come from flops
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         txqIrq_r  <= 1'b0;
         rxq1Irq_r <= 1'b0;
         rxq2Irq_r <= 1'b0;
      end else begin
         txqIrq_r  <= txqHit;                                                  // R07
         rxq1Irq_r <= rxq1Hit;                                                 // R08
         rxq2Irq_r <= rxq2Hit;
      end
   end

   // ==========================================================
   // outputs
   assign pready            = pready_r;
   assign prdata            = prdata_r;
   assign pslverr           = pslverr_r;
   assign dmaReq            = dmaReq_r;
   assign dmaAddr           = dmaAddr_r;
   assign dmaWide           = dmaWide_r;
   assign dmaWords          = dmaWords_r;
   assign entryWritten      = entryWritten_r;
   assign txqCompletionIrq  = txqIrq_r;
   assign rxq1CompletionIrq = rxq1Irq_r;
   assign rxq2CompletionIrq = rxq2Irq_r;

endmodule // completion_queue_control

// File: hdl/completion_queue_pkg.sv
package completion_queue_pkg;

   // descriptor engine states
   typedef enum logic [0:0] {
      ENG_IDLE,
      ENG_WRITE
   } engine_state_t;

   // entry formats of the second receive queue
   typedef enum logic [1:0] {
      FMT_ONE_WORD    = 2'h0,
      FMT_TWO_VLAN    = 2'h1,
      FMT_TWO_CSUM    = 2'h2,
      FMT_FOUR_WORD   = 2'h3
   } entry_format_t;

endpackage

// File: hdl/queue_tracker.sv
`timescale 1ns/1ps
`include "completion_queue_cfg.svh"

module queue_tracker (
   input  wire logic [9:0] producer,     // producer index
   input  wire logic [9:0] consumer,     // consumer index
   input  wire logic [3:0] thresholdFld, // threshold field
   input  wire logic       sense,        // 1: valid count, 0: empty count
   output logic            empty,        // queue empty
   output logic            full,         // queue full
   output logic            thresholdHit  // threshold condition met
);

   // ==========================================================
   // occupancy and threshold
   logic [9:0] validCount;
   logic [9:0] emptyCount;
   logic [9:0] threshold;

   // index arithmetic is modulo 1024, so wrap comes for free
   assign validCount   = producer - consumer;
   assign emptyCount   = `QUEUE_LAST_ENTRY - validCount;
   assign threshold    = {4'h0, thresholdFld, 2'h0};                          // R06
   assign empty        = (producer == consumer);                              // R09
   assign full         = (10'(producer + 10'h001) == consumer);               // R10
   assign thresholdHit = sense ? (validCount >= threshold)                    // R07 R08
                               : (emptyCount <= threshold);

endmodule // queue_tracker

// File: verification/completion_queue_control_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench for the completion queue block
module completion_queue_control_tb_top;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [9:0]  txqProducer = 10'h000;
   logic [9:0]  rxq1Producer = 10'h000;
   logic        entryReq = 1'b0;
   logic [3:0]  memLatency = 4'h0;
   logic        pready, pslverr, dmaDone, dmaReq, dmaWide, entryWritten;
   logic        txIrq, rxq1Irq, rxq2Irq;
   logic [31:0] prdata, dmaAddr, rd;
   logic [2:0]  dmaWords;
   logic        err;
   int          n_fail = 0;
   int          n_tests = 0;

   always #2.5 clock = ~clock;

   completion_queue_control dut (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .txqProducer(txqProducer),
      .rxq1Producer(rxq1Producer), .entryReq(entryReq), .dmaDone(dmaDone), .dmaReq(dmaReq),
      .dmaAddr(dmaAddr), .dmaWide(dmaWide), .dmaWords(dmaWords), .entryWritten(entryWritten),
      .txqCompletionIrq(txIrq), .rxq1CompletionIrq(rxq1Irq), .rxq2CompletionIrq(rxq2Irq));
   host_memory_model u_host (.clock(clock), .reset_n(reset_n), .dmaReq(dmaReq),
      .latency(memLatency), .dmaDone(dmaDone));

   // ==========================================================
   // report and compare
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmpBit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // wait on a falling edge so the sampled level has settled; bounded
   task automatic waitHigh(input int which);
      int i;
      i = 0;
      @(negedge clock);
      while ((which == 0 ? dmaReq : entryWritten) !== 1'b1) begin
         i++;
         if (i > 40) begin
            n_fail++;
            end_of_test();
         end
         @(negedge clock);
      end
   endtask

   // ==========================================================
   // apb master: request held until the edge where ready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      // ready and data read as sampled at the edge, before its updates land
      do begin
         @(posedge clock);
         i++;
      end while (pready !== 1'b1 && i < 40);
      if (pready !== 1'b1) begin
         n_fail++;
         end_of_test();
      end
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      cmpWord(rd, exp);
      cmpBit(err, 1'b0);
   endtask
   // one row of the threshold table, both lower queues at once
   task automatic threshRow(input logic s, input logic [9:0] p, input logic [9:0] c,
                            input logic h);
      logic e;
      logic fl;
      e  = (p == c);
      fl = (p + 10'h001 == c);
      apb(1'b1, 12'h0C4, {s, 5'h00, c, s, 5'h00, c});
      @(posedge clock);
      txqProducer  <= p;
      rxq1Producer <= p;
      repeat (3) @(posedge clock);
      @(negedge clock);
      cmpBit(txIrq, h);
      cmpBit(rxq1Irq, h);
      apb(1'b0, 12'h0E8, 32'h0000_0000);
      cmpWord(rd & 32'h0000_003F, {26'h0, h, fl, e, h, fl, e});
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] base;
      logic [31:0] ctl;
      logic [9:0]  prod;
      int          seen;
      base = 32'h1234_5600;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      rdChk(12'h0C0, 32'h0000_0000);
      rdChk(12'h0C4, 32'h0000_0000);
      apb(1'b0, 12'h0D0, 32'h0000_0000);
      cmpBit(err, 1'b1);
      cmpWord(rd, 32'h0000_0000);
      apb(1'b1, 12'h0C4, 32'hFFFF_FFFF);
      rdChk(12'h0C4, 32'h83FF_83FF);
      // producer writes only land while the queue is held off
      apb(1'b1, 12'h0E0, 32'h0005_0000);
      rdChk(12'h0E0, 32'h0000_0000);
      apb(1'b1, 12'h0C0, 32'h0000_0040);
      apb(1'b1, 12'h0E0, 32'h03FF_000A);
      rdChk(12'h0E0, 32'h03FF_000A);
      prod = 10'h3FF;
      // every format once, starting at the last index so the first step wraps
      for (int f = 0; f < 4; f++) begin
         ctl = base | (32'(f[1]) << 7) | (32'(f) << 4);
         apb(1'b1, 12'h0C0, ctl);
         rdChk(12'h0C0, ctl);
         memLatency <= f[0] ? 4'h3 : 4'h0;
         entryReq   <= 1'b1;
         waitHigh(0);
         cmpWord(dmaAddr, base + (32'(prod) << (f[1] ? 3 : 2)));
         cmpBit(dmaWide, f[1]);
         cmpWord({29'h0, dmaWords}, (f == 3) ? 32'h4 : ((f == 0) ? 32'h1 : 32'h2));
         @(posedge clock);
         entryReq <= 1'b0;
         waitHigh(1);
         prod = prod + 10'h001;
         rdChk(12'h0E0, {6'h00, prod, 16'h000A});
      end
      // full queue: no request while the entry waits 20 cycles
      apb(1'b1, 12'h0E0, {22'h0, prod + 10'h001});
      apb(1'b0, 12'h0E8, 32'h0000_0000);
      cmpWord(rd & 32'h0000_01C0, 32'h0000_0180);
      cmpBit(rxq2Irq, 1'b1);
      entryReq <= 1'b1;
      seen = 0;
      repeat (20) begin
         @(negedge clock);
         if (dmaReq !== 1'b0) seen++;
      end
      cmpWord(seen, 32'h0000_0000);
      @(posedge clock);
      entryReq <= 1'b0;
      apb(1'b1, 12'h0E0, {22'h0, prod});
      apb(1'b0, 12'h0E8, 32'h0000_0000);
      cmpWord(rd & 32'h0000_01C0, 32'h0000_0040);
      // second receive threshold: field one means four valid entries
      apb(1'b1, 12'h0C0, ctl | 32'h0000_0001);
      apb(1'b1, 12'h0E0, {16'h0000, 1'b1, 5'h00, prod - 10'h004});
      apb(1'b0, 12'h0E8, 32'h0000_0000);
      cmpWord(rd & 32'h0000_0100, 32'h0000_0100);
      cmpBit(rxq2Irq, 1'b1);
      apb(1'b1, 12'h0E0, {16'h0000, 1'b1, 5'h00, prod - 10'h003});
      apb(1'b0, 12'h0E8, 32'h0000_0000);
      cmpWord(rd & 32'h0000_0100, 32'h0000_0000);
      cmpBit(rxq2Irq, 1'b0);
      // threshold of eight on both lower queues
      apb(1'b1, 12'h0E4, 32'h0000_0202);
      threshRow(1'b1, 10'd4, 10'd1020, 1'b1);
      threshRow(1'b1, 10'd3, 10'd1020, 1'b0);
      threshRow(1'b0, 10'd1015, 10'd0, 1'b1);
      threshRow(1'b0, 10'd1014, 10'd0, 1'b0);
      threshRow(1'b0, 10'd9, 10'd10, 1'b1);
      threshRow(1'b1, 10'd7, 10'd7, 1'b0);
      end_of_test();
   end
endmodule // completion_queue_control_tb_top

// File: verification/completion_queue_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// port checker for the completion queue block
module completion_queue_monitor (
   input wire logic        clock,        // core clock
   input wire logic        reset_n,      // asynchronous reset, active low
   input wire logic        psel,         // apb select
   input wire logic        penable,      // apb enable
   input wire logic        pwrite,       // apb direction
   input wire logic [11:0] paddr,        // apb byte address
   input wire logic        pready,       // apb ready
   input wire logic [31:0] prdata,       // apb read data
   input wire logic        dmaReq,       // entry write request
   input wire logic        dmaDone,      // entry delivered
   input wire logic [31:0] dmaAddr,      // entry host address
   input wire logic        dmaWide,      // 64-bit cycles
   input wire logic [2:0]  dmaWords,     // entry length
   input wire logic        entryWritten  // delivery pulse
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // register access
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held beyond one cycle");
   a_reserved_zero: assert property (pready && !pwrite && paddr == 12'h0C4
      |-> prdata[30:26] == 5'h00 && prdata[14:10] == 5'h00)
      else $error("reserved consumer bits read nonzero");

   // ==========================================================
   // entry engine: a request must not move while the host is still working on it
   a_words_format: assert property (dmaReq |-> dmaWords inside {3'h1, 3'h2, 3'h4})
      else $error("illegal entry length");
   a_request_held: assert property (dmaReq && !dmaDone |=> dmaReq && $stable(dmaAddr)
      && $stable(dmaWide) && $stable(dmaWords))
      else $error("request changed before completion");
   a_done_advances: assert property (dmaReq && dmaDone |=> !dmaReq && entryWritten)
      else $error("completion not followed by delivery pulse");
   a_written_alone: assert property (entryWritten |-> !dmaReq ##1 !entryWritten)
      else $error("delivery pulse overlaps request or lasts");
   a_written_cause: assert property (entryWritten |-> $past(dmaDone) && $past(dmaReq))
      else $error("delivery pulse without completion");
   a_addr_aligned: assert property (dmaReq |-> dmaAddr[1:0] == 2'b00
      && (dmaWords != 3'h4 || dmaAddr[2] == 1'b0))
      else $error("entry address misaligned");
endmodule // completion_queue_monitor

bind completion_queue_control completion_queue_monitor u_monitor (
   .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pready(pready), .prdata(prdata), .dmaReq(dmaReq), .dmaDone(dmaDone),
   .dmaAddr(dmaAddr), .dmaWide(dmaWide), .dmaWords(dmaWords), .entryWritten(entryWritten)
);

// File: verification/host_memory_model.sv
`timescale 1ns/1ps
// ==========================================================
// host memory behind the bus master, answers each entry after a set wait
module host_memory_model (
   input  wire logic       clock,    // core clock
   input  wire logic       reset_n,  // asynchronous reset, active low
   input  wire logic       dmaReq,   // entry write request
   input  wire logic [3:0] latency,  // wait cycles before completion
   output logic            dmaDone   // one-cycle completion pulse
);
   logic [3:0] waitCnt_r;

   // no answer at the edge after a pulse, since the request is still high there
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         waitCnt_r <= 4'h0;
         dmaDone   <= 1'b0;
      end else if (dmaReq && !dmaDone && waitCnt_r >= latency) begin
         waitCnt_r <= 4'h0;
         dmaDone   <= 1'b1;
      end else begin
         waitCnt_r <= (dmaReq && !dmaDone) ? waitCnt_r + 4'h1 : 4'h0;
         dmaDone   <= 1'b0;
      end
   end
endmodule // host_memory_model
